//--- rtl/irq_bank_pkg.sv
// Purpose: Shared constants for the interrupt flag and enable bank.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes:   Masks mark the implemented bits of each 16-bit register.
package irq_bank_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_FLAGS1 = 8'h00;
    localparam logic [7:0] OFF_FLAGS2 = 8'h04;
    localparam logic [7:0] OFF_FLAGS3 = 8'h08;
    localparam logic [7:0] OFF_FLAGS4 = 8'h0C;
    localparam logic [7:0] OFF_ENABLES0 = 8'h10;
    localparam logic [7:0] OFF_EVT_STAT = 8'h14;
    localparam logic [7:0] OFF_EVT_MASK = 8'h18;

    // ****************************************************************
    // Field layout and reset values
    // ****************************************************************
    localparam int REG_W = 16;
    localparam int GROUPS = 4;
    // Pin change at 3, bit 2 empty, I2C one master at 1, slave at 0.
    localparam logic [15:0] MASK_FLAGS1 = 16'h000B;
    // Timer six 15, DMA ch4 14, bit 13 empty, 12..0 compare, capture,
    // DMA ch3, CAN one and SPI two sources.
    localparam logic [15:0] MASK_FLAGS2 = 16'hDFFF;
    // DMA ch5 at 13, CAN two at 8..7, pins 6..5, timers and I2C two 4..0.
    localparam logic [15:0] MASK_FLAGS3 = 16'h21FF;
    // CAN tx 7..6, DMA ch7..6 at 5..4, UART errors at 2..1.
    localparam logic [15:0] MASK_FLAGS4 = 16'h00F6;
    // Bit 15 empty; DMA ch1 down to external pin 0 at 14..0.
    localparam logic [15:0] MASK_ENABLES0 = 16'h7FFF;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [3:0] RESET_GROUP = 4'h0;
    localparam logic [31:0] RESET_DATA = 32'h0000_0000;
    localparam int PIN_CHANGE_BIT = 3;
    localparam int DMA_CH5_BIT = 13;

endpackage : irq_bank_pkg

//--- rtl/irq_flag_word.sv
// Purpose: One 16-bit flag or enable word with hardware set and software write.
// Assumes: Set strobes come from logic on pclk.
// Notes:   Bits outside IMPL never store anything and read as zero.
`timescale 1ns/100ps
module irq_flag_word #(
    parameter logic [15:0] IMPL = 16'hFFFF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] hw_set,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    output logic [15:0] value
);

    typedef struct packed {
        logic [15:0] val;
    } word_s;

    word_s st_q;
    word_s st_d;

    // A set in the same cycle as a software clear wins, so no event is lost.
    always_comb begin
        st_d = st_q;
        if (wr_en) begin
            st_d.val = wr_data;
        end
        st_d.val = (st_d.val | hw_set) & IMPL;
    end

    // Power-on reset clears every bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{val: irq_bank_pkg::RESET_WORD};
        end else begin
            st_q <= st_d;
        end
    end

    assign value = st_q.val;

endmodule : irq_flag_word

//--- rtl/irq_flag_bank.sv
// Purpose: Interrupt flag and enable bank reached over APB.
// Assumes: Request strobes and group0 flags come from logic on pclk.
// Notes:   Zero wait state APB, registered answer in the access phase.
`timescale 1ns/100ps

module irq_flag_bank (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] req_flags1,
    input wire logic [15:0] req_flags2,
    input wire logic [15:0] req_flags3,
    input wire logic [15:0] req_flags4,
    input wire logic [15:0] src_flags0,
    output logic [15:0] flags1,
    output logic [15:0] flags2,
    output logic [15:0] flags3,
    output logic [15:0] flags4,
    output logic [15:0] enables0,
    output logic [15:0] core_req,
    output logic irq
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [3:0] evt_stat;
        logic [3:0] evt_mask;
        logic [15:0] core_req;
        logic irq;
    } bank_s;

    bank_s st_q;
    bank_s st_d;

    logic setup;
    logic access;
    logic wr;
    logic hit;
    logic [31:0] rd_word;
    logic [15:0] ev_m1;
    logic [15:0] ev_m2;
    logic [15:0] ev_m3;
    logic [15:0] ev_m4;
    logic [3:0] grp_ev;
    logic [15:0] en_next;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    // The access phase is only complete when our own pready is high,
    // so a write lands exactly once per transfer.
    assign setup = psel & ~penable;
    assign access = psel & penable & st_q.pready;
    assign wr = access & pwrite;

    // Request strobes reduced to implemented positions.
    assign ev_m1 = req_flags1 & irq_bank_pkg::MASK_FLAGS1;
    assign ev_m2 = req_flags2 & irq_bank_pkg::MASK_FLAGS2;
    assign ev_m3 = req_flags3 & irq_bank_pkg::MASK_FLAGS3;
    assign ev_m4 = req_flags4 & irq_bank_pkg::MASK_FLAGS4;
    assign grp_ev = {|ev_m4, |ev_m3, |ev_m2, |ev_m1};

    // ****************************************************************
    // Flag and enable words
    // ****************************************************************
    irq_flag_word #(
        .IMPL(irq_bank_pkg::MASK_FLAGS1)
    ) u_flags1 (
        .pclk(pclk),
        .presetn(presetn),
        .hw_set(ev_m1),
        .wr_en(wr && paddr == irq_bank_pkg::OFF_FLAGS1),
        .wr_data(pwdata[15:0]),
        .value(flags1)
    );

    irq_flag_word #(
        .IMPL(irq_bank_pkg::MASK_FLAGS2)
    ) u_flags2 (
        .pclk(pclk),
        .presetn(presetn),
        .hw_set(ev_m2),
        .wr_en(wr && paddr == irq_bank_pkg::OFF_FLAGS2),
        .wr_data(pwdata[15:0]),
        .value(flags2)
    );

    irq_flag_word #(
        .IMPL(irq_bank_pkg::MASK_FLAGS3)
    ) u_flags3 (
        .pclk(pclk),
        .presetn(presetn),
        .hw_set(ev_m3),
        .wr_en(wr && paddr == irq_bank_pkg::OFF_FLAGS3),
        .wr_data(pwdata[15:0]),
        .value(flags3)
    );

    irq_flag_word #(
        .IMPL(irq_bank_pkg::MASK_FLAGS4)
    ) u_flags4 (
        .pclk(pclk),
        .presetn(presetn),
        .hw_set(ev_m4),
        .wr_en(wr && paddr == irq_bank_pkg::OFF_FLAGS4),
        .wr_data(pwdata[15:0]),
        .value(flags4)
    );

    // Enables have no hardware source; only software changes them.
    irq_flag_word #(
        .IMPL(irq_bank_pkg::MASK_ENABLES0)
    ) u_enables0 (
        .pclk(pclk),
        .presetn(presetn),
        .hw_set(irq_bank_pkg::RESET_WORD),
        .wr_en(wr && paddr == irq_bank_pkg::OFF_ENABLES0),
        .wr_data(pwdata[15:0]),
        .value(enables0)
    );

    // Next enable value, so the core request follows a write at once.
    always_comb begin
        en_next = enables0;
        if (wr && paddr == irq_bank_pkg::OFF_ENABLES0) begin
            en_next = pwdata[15:0] & irq_bank_pkg::MASK_ENABLES0;
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    // Upper sixteen bits and empty positions always read as zero.
    always_comb begin
        rd_word = irq_bank_pkg::RESET_DATA;
        hit = 1'b1;
        case (paddr)
            irq_bank_pkg::OFF_FLAGS1: rd_word[15:0] = flags1;
            irq_bank_pkg::OFF_FLAGS2: rd_word[15:0] = flags2;
            irq_bank_pkg::OFF_FLAGS3: rd_word[15:0] = flags3;
            irq_bank_pkg::OFF_FLAGS4: rd_word[15:0] = flags4;
            irq_bank_pkg::OFF_ENABLES0: rd_word[15:0] = enables0;
            irq_bank_pkg::OFF_EVT_STAT: rd_word[3:0] = st_q.evt_stat;
            irq_bank_pkg::OFF_EVT_MASK: rd_word[3:0] = st_q.evt_mask;
            default: hit = 1'b0;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Bus answer, group event status, mask, core requests and irq.
    always_comb begin
        st_d = st_q;
        st_d.pready = setup;
        st_d.pslverr = setup & ~hit;
        st_d.prdata = irq_bank_pkg::RESET_DATA;
        if (setup && !pwrite) begin
            st_d.prdata = rd_word;
        end
        if (wr && paddr == irq_bank_pkg::OFF_EVT_STAT) begin
            st_d.evt_stat = st_q.evt_stat & ~pwdata[3:0];
        end
        // A new event in the clear cycle is kept.
        st_d.evt_stat = st_d.evt_stat | grp_ev;
        if (wr && paddr == irq_bank_pkg::OFF_EVT_MASK) begin
            st_d.evt_mask = pwdata[3:0];
        end
        st_d.core_req = src_flags0 & en_next;
        st_d.irq = |(st_d.evt_stat & st_d.evt_mask);
    end

    // Single register stage for bus answer, event status, mask, core requests and irq.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '{prdata: irq_bank_pkg::RESET_DATA,
                      pready: 1'b0,
                      pslverr: 1'b0,
                      evt_stat: irq_bank_pkg::RESET_GROUP,
                      evt_mask: irq_bank_pkg::RESET_GROUP,
                      core_req: irq_bank_pkg::RESET_WORD,
                      irq: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign core_req = st_q.core_req;
    assign irq = st_q.irq;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Helper: write data as seen by the flag words.
    logic [15:0] wdat;
    assign wdat = pwdata[15:0];

    property p_hw_set;
        (|ev_m2) |=> ((flags2 & $past(ev_m2)) == $past(ev_m2));
    endproperty
    a_hw_set: assert property (p_hw_set)
        else $error("Request strobe did not set its flag.");

    // Software may clear the flag the cycle after it was set, so only an
    // undisturbed cycle is required to keep it.
    property p_pin_change;
        req_flags1[irq_bank_pkg::PIN_CHANGE_BIT] ##1 !(wr && paddr == irq_bank_pkg::OFF_FLAGS1)
            |-> flags1[irq_bank_pkg::PIN_CHANGE_BIT] [*2];
    endproperty
    a_pin_change: assert property (p_pin_change)
        else $error("Pin change flag lost before any write.");

    property p_set_wins;
        (wr && paddr == irq_bank_pkg::OFF_FLAGS3 && wdat == 16'h0000 && ev_m3[13])
            |=> flags3[irq_bank_pkg::DMA_CH5_BIT];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("Clear overrode a same-cycle request.");

    property p_unimpl;
        ((flags1 & ~irq_bank_pkg::MASK_FLAGS1) == 16'h0000)
            && ((flags2 & ~irq_bank_pkg::MASK_FLAGS2) == 16'h0000)
            && ((flags3 & ~irq_bank_pkg::MASK_FLAGS3) == 16'h0000)
            && ((flags4 & ~irq_bank_pkg::MASK_FLAGS4) == 16'h0000)
            && ((enables0 & ~irq_bank_pkg::MASK_ENABLES0) == 16'h0000);
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("An empty bit position holds a one.");

    property p_reset_clear;
        $rose(presetn) |-> (enables0 == 16'h0000 && st_q.evt_mask == 4'h0);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("Enables or mask not cleared by reset.");

    property p_en_write;
        (wr && paddr == irq_bank_pkg::OFF_ENABLES0)
            |=> (enables0 == ($past(wdat) & 16'h7FFF));
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("Enable write did not store the written bits.");

    property p_flag_write;
        (wr && paddr == irq_bank_pkg::OFF_FLAGS4 && ev_m4 == 16'h0000)
            |=> (flags4 == ($past(wdat) & 16'h00F6));
    endproperty
    a_flag_write: assert property (p_flag_write)
        else $error("Flag write did not store the written bits.");

    property p_core_req;
        core_req == ($past(src_flags0) & enables0);
    endproperty
    a_core_req: assert property (p_core_req)
        else $error("Core request not equal to flag and enable.");

    sequence s_read3;
        setup && !pwrite && paddr == irq_bank_pkg::OFF_FLAGS3;
    endsequence

    property p_read3;
        s_read3 |=> (pready && prdata == {16'h0000, $past(flags3)});
    endproperty
    a_read3: assert property (p_read3)
        else $error("Read of group3 flags returned wrong data.");

    property p_bus_answer;
        setup |=> (pready && penable) ##1 !pready;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("Access phase did not end after one cycle.");

    property p_irq;
        irq == (|(st_q.evt_stat & st_q.evt_mask));
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt line disagrees with status and mask.");

    // An unmapped address answers with an error and zero data.
    property p_slverr;
        (setup && !hit) |=> (pready && pslverr && prdata == irq_bank_pkg::RESET_DATA);
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("Unmapped access did not answer with an error.");

    // A group event is recorded even when software clears status in that cycle.
    property p_evt_set;
        (|grp_ev) |=> ((st_q.evt_stat & $past(grp_ev)) == $past(grp_ev));
    endproperty
    a_evt_set: assert property (p_evt_set)
        else $error("Group event not recorded in status.");

    // An event of an unmasked group raises the line at the next edge.
    property p_irq_rise;
        (|(grp_ev & st_q.evt_mask)) && !(wr && paddr == irq_bank_pkg::OFF_EVT_MASK) |=> irq;
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("Unmasked event did not raise the interrupt line.");

    // With every enable off and no enable write, no request reaches the core.
    property p_en_gate;
        (enables0 == 16'h0000) && !(wr && paddr == irq_bank_pkg::OFF_ENABLES0)
            |=> (core_req == 16'h0000);
    endproperty
    a_en_gate: assert property (p_en_gate)
        else $error("Core request passed with every enable off.");

    // A set flag holds until software writes its word.
    property p_flag_hold;
        flags3[irq_bank_pkg::DMA_CH5_BIT] && !(wr && paddr == irq_bank_pkg::OFF_FLAGS3)
            |=> flags3[irq_bank_pkg::DMA_CH5_BIT];
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("Flag dropped without a software write.");

    c_set_then_clear: cover property (
        (|ev_m2) ##[1:20] (wr && paddr == irq_bank_pkg::OFF_FLAGS2));
    c_core_req: cover property ($rose(|core_req));
    c_irq: cover property ($rose(irq) ##[1:30] $fell(irq));
    c_slverr: cover property (pslverr);

endmodule : irq_flag_bank

//--- testbench/irq_source_model.sv
// Purpose: Peripheral interrupt sources that face the flag bank.
// Assumes: Bench commands change just after a rising pclk edge.
// Notes:   Group requests are pulses; group0 sources are a held level.
`timescale 1ns/100ps
module irq_source_model (
    input wire logic fire,
    input wire logic [2:0] grp,
    input wire logic [15:0] bits,
    input wire logic [15:0] level0,
    output logic [15:0] req1,
    output logic [15:0] req2,
    output logic [15:0] req3,
    output logic [15:0] req4,
    output logic [15:0] src0
);
    // Strobes last one cycle only, so a flag seen later proves it was stored.
    assign req1 = (fire && grp == 3'h1) ? bits : 16'h0000;
    assign req2 = (fire && grp == 3'h2) ? bits : 16'h0000;
    assign req3 = (fire && grp == 3'h3) ? bits : 16'h0000;
    assign req4 = (fire && grp == 3'h4) ? bits : 16'h0000;
    // Group0 flags live elsewhere and arrive as a steady level.
    assign src0 = level0;
endmodule : irq_source_model

//--- testbench/interrupt_flag_enable_bank_tb_top.sv
// Purpose: Self-checking bench for the interrupt flag and enable bank.
// Assumes: Zero wait state APB slave; the master still waits for pready.
// Notes:   Register rows run in two loops; events and reset follow by hand.
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module interrupt_flag_enable_bank_tb_top;
    typedef struct {logic [2:0] grp; logic [7:0] addr; logic [15:0] impl;} row_s;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, irq, err, fire = 1'b0;
    logic [2:0] grp = 3'h0;
    logic [15:0] bits = 16'h0000, level0 = 16'h0000;
    logic [15:0] req1, req2, req3, req4, src0, core_req;
    logic [15:0] fw [0:4];
    int error_cnt = 0, comparisons = 0;
    // Implemented bits of each word, written out from the bit layouts.
    row_s rows [5] = '{'{3'h1, 8'h00, 16'h000B},
        '{3'h2, 8'h04, 16'hDFFF},
        '{3'h3, 8'h08, 16'h21FF},
        '{3'h4, 8'h0C, 16'h00F6},
        '{3'h0, 8'h10, 16'h7FFF}};

    // Free-running 100 MHz clock.
    always #5 pclk = ~pclk;

    irq_source_model peers (.fire(fire), .grp(grp), .bits(bits), .level0(level0),
        .req1(req1), .req2(req2), .req3(req3), .req4(req4), .src0(src0));
    irq_flag_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .req_flags1(req1), .req_flags2(req2),
        .req_flags3(req3), .req_flags4(req4), .src_flags0(src0), .flags1(fw[1]),
        .flags2(fw[2]), .flags3(fw[3]), .flags4(fw[4]), .enables0(fw[0]),
        .core_req(core_req), .irq(irq));

    // One APB transfer; keep leaves psel up so a setup follows at once.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic keep);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20) `CHK(pready, 1'b1)
        penable <= 1'b0;
        // An idle edge after a release keeps psel from two writes in one step.
        if (!keep) begin
            psel <= 1'b0;
            @(posedge pclk);
        end
    endtask : xfer

    // One-cycle request pulse from the chosen source group.
    task automatic pulse(input logic [2:0] g, input logic [15:0] b);
        fire <= 1'b1;
        grp <= g;
        bits <= b;
        @(posedge pclk);
        fire <= 1'b0;
    endtask : pulse

    task automatic finish_test;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    // A hang costs a mismatch; the whole run needs well under this span.
    initial begin
        repeat (4000) @(posedge pclk);
        error_cnt++;
        finish_test();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, rows[i].addr, 32'h0, 1'b0);
            `CHK(rd, 32'h0000_0000)
        end
        $display("reset values done");
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, rows[i].addr, 32'hFFFF_FFFF, 1'b1);
            xfer(1'b0, rows[i].addr, 32'h0, 1'b0);
            `CHK(rd, {16'h0000, rows[i].impl})
            xfer(1'b1, rows[i].addr, 32'h0, 1'b1);
            xfer(1'b0, rows[i].addr, 32'h0, 1'b0);
            `CHK(rd, 32'h0000_0000)
            if (rows[i].grp != 3'h0) begin
                pulse(rows[i].grp, 16'hFFFF);
                repeat (4) @(posedge pclk);
                `CHK(fw[rows[i].grp], rows[i].impl)
                xfer(1'b0, 8'h14, 32'h0, 1'b0);
                `CHK(rd, 32'h1 << (rows[i].grp - 3'h1))
                xfer(1'b1, 8'h14, 32'h0000_000F, 1'b1);
                xfer(1'b1, rows[i].addr, 32'h0, 1'b0);
                @(posedge pclk);
                `CHK(fw[rows[i].grp], 16'h0000)
            end
        end
        $display("register rows done");
        // Unmapped word: refused with an error and zero data.
        xfer(1'b0, 8'h1C, 32'h0, 1'b0);
        `CHK({err, rd}, {1'b1, 32'h0000_0000})
        $display("unmapped done");
        // Masked-in event raises the line; clearing status drops it.
        xfer(1'b1, 8'h18, 32'h0000_0002, 1'b0);
        pulse(3'h2, 16'h0020);
        @(posedge pclk);
        `CHK({irq, fw[2]}, {1'b1, 16'h0020})
        xfer(1'b1, 8'h14, 32'h0000_0002, 1'b1);
        xfer(1'b1, 8'h18, 32'h0000_0000, 1'b0);
        repeat (2) @(posedge pclk);
        `CHK({irq, fw[2]}, {1'b0, 16'h0020})
        pulse(3'h2, 16'h0020);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        $display("event line done");
        // A request in the very edge that clears its word still sets the flag.
        fork
            xfer(1'b1, 8'h08, 32'h0, 1'b0);
            begin
                @(posedge pclk);
                pulse(3'h3, 16'h2000);
            end
        join
        `CHK(fw[3], 16'h2000)
        $display("set wins done");
        // Enable gating of the group0 sources, bit 15 included.
        level0 <= 16'hFFFF;
        xfer(1'b1, 8'h10, 32'h0000_FFFF, 1'b0);
        repeat (2) @(posedge pclk);
        `CHK(core_req, 16'h7FFF)
        xfer(1'b1, 8'h10, 32'h0000_0005, 1'b0);
        level0 <= 16'h0004;
        repeat (2) @(posedge pclk);
        `CHK(core_req, 16'h0004)
        $display("enable gating done");
        // A second reset in mid-run clears flags1, flags2, enables0 and irq.
        xfer(1'b1, 8'h00, 32'h0000_000B, 1'b0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK({fw[1], fw[2], fw[0], irq}, 49'h0)
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(1'b0, 8'h04, 32'h0, 1'b0);
        `CHK(rd, 32'h0000_0000)
        $display("mid-run reset done");
        finish_test();
    end
endmodule : interrupt_flag_enable_bank_tb_top
